// ### acpf_params.svh
// constants for the converter control block
`ifndef ACPF_PARAMS_SVH
`define ACPF_PARAMS_SVH
`define ACPF_RES_BITS      10
`define ACPF_CMP_BITS      8
`define ACPF_CHAN_BITS     3
`define ACPF_RATE_BITS     3
`define ACPF_SAMPLE_DIV    6
`define ACPF_FIRST_EXTRA   36
`define ACPF_SETTLE_NS     14000
`define ACPF_CLK_NS        100
`define ACPF_SETTLE_CYC    ((`ACPF_SETTLE_NS + `ACPF_CLK_NS - 1) / `ACPF_CLK_NS)
`define ACPF_RESULT_RST    10'h000
`endif

// ### acpf_pkg.sv
// types for the converter control block
package acpf_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT
	} acpf_state_e;
endpackage : acpf_pkg

// ### acpf_sar.sv
// successive approximation core: one result bit per step
`timescale 1ns/1ps
`default_nettype none
`include "acpf_params.svh"
module acpf_sar #(
	parameter int W = `ACPF_RES_BITS
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         clear_i,
	input  wire logic         step_i,
	input  wire logic         comp_ge_i,
	output logic [W-1:0]      trial_o,
	output logic              done_o
);
	typedef struct packed {
		logic [W-1:0] sar;
		logic [W-1:0] bitm;
	} acpf_sar_s;
	acpf_sar_s s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (clear_i) begin
			s_d.sar  = {1'b1, {(W-1){1'b0}}};
			s_d.bitm = {1'b1, {(W-1){1'b0}}};
		end else if (step_i && s_q.bitm != '0) begin
			// keep the trial bit only if the input is at or above the tap
			if (!comp_ge_i)
				s_d.sar = s_q.sar & ~s_q.bitm;
			s_d.bitm = s_q.bitm >> 1;
			s_d.sar  = s_d.sar | (s_q.bitm >> 1);
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign trial_o = s_q.sar;
	assign done_o  = (s_q.bitm == '0);
endmodule : acpf_sar
`default_nettype wire

// ### acpf_ctrl.sv
// converter control with power-fail compare
// Contract
// - latch result, compare top byte, gate interrupt
// - channel-change conversion takes rate time exactly
// - ten-bit result, 1/1024 full scale
// - standby stops the converter
// - result read wins over result write
// - mode/channel write suppresses result and interrupt
// - channel write keeps interrupt flag
// - sample about one sixth of time
// - conversion time includes sampling
// - mode 0 ge, mode 1 below threshold
// - register rewrite restarts current conversion
// - conversions repeat until start cleared
// - clearing start stops immediately
`timescale 1ns/1ps
`default_nettype none
`include "acpf_params.svh"
module acpf_ctrl #(
	parameter int RES   = `ACPF_RES_BITS,
	parameter int SETTLE = `ACPF_SETTLE_CYC
) (
	input  wire logic                       clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       converter_enable_bit_i,
	input  wire logic                       conversion_start_bit_i,
	input  wire logic [`ACPF_RATE_BITS-1:0] conversion_rate_field_i,
	input  wire logic [`ACPF_CHAN_BITS-1:0] channel_select_field_i,
	input  wire logic                       power_fail_enable_bit_i,
	input  wire logic                       compare_condition_bit_i,
	input  wire logic [`ACPF_CMP_BITS-1:0]  threshold_i,
	input  wire logic                       mode_wr_i,
	input  wire logic                       channel_wr_i,
	input  wire logic                       cmpmode_wr_i,
	input  wire logic                       threshold_wr_i,
	input  wire logic                       result_rd_i,
	input  wire logic                       irq_flag_clr_i,
	input  wire logic                       standby_i,
	input  wire logic                       comp_ge_i,
	output logic [RES-1:0]                  dac_code_o,
	output logic [`ACPF_CHAN_BITS-1:0]      mux_sel_o,
	output logic                            sample_o,
	output logic [RES-1:0]                  conversion_result_o,
	output logic                            conversion_end_irq_o,
	output logic                            conversion_irq_flag_o,
	output logic                            busy_o,
	output logic                            settled_o
);
	typedef struct packed {
		acpf_pkg::acpf_state_e  st;
		logic [9:0]             cnt;
		logic [9:0]             samp;
		logic [5:0]             step;
		logic                   first;
		logic [RES-1:0]         result;
		logic [RES-1:0]         held;
		logic                   pend;
		logic                   irq;
		logic                   flag;
		logic [14:0]            settle;
		logic                   settled;
		logic [`ACPF_CHAN_BITS-1:0] mux;
		logic                   sample;
		logic                   busy;
	} acpf_ctrl_s;
	acpf_ctrl_s s_q, s_d;

	logic [RES-1:0] trial;
	logic           sar_done;
	logic           sar_clear;
	logic           sar_step;
	logic [9:0]     conv_cyc;
	logic           reg_wr;
	logic           hit;
	logic           end_ev;

	// conversion time in clocks of the converter clock
	always_comb begin
		case (conversion_rate_field_i)
			3'h0:    conv_cyc = 10'd288;
			3'h1:    conv_cyc = 10'd240;
			3'h2:    conv_cyc = 10'd192;
			3'h4:    conv_cyc = 10'd144;
			3'h5:    conv_cyc = 10'd120;
			3'h6:    conv_cyc = 10'd96;
			default: conv_cyc = 10'd288;
		endcase
	end

	assign reg_wr = mode_wr_i | channel_wr_i | cmpmode_wr_i | threshold_wr_i;
	// compare on the upper byte of the fresh result
	assign hit = compare_condition_bit_i ?
		(trial[RES-1 -: `ACPF_CMP_BITS] < threshold_i) :
		(trial[RES-1 -: `ACPF_CMP_BITS] >= threshold_i);
	assign end_ev = (s_q.st == acpf_pkg::ST_CONVERT) && (s_q.cnt == 10'd1);

	acpf_sar #(.W(RES)) u_sar (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.clear_i   (sar_clear),
		.step_i    (sar_step),
		.comp_ge_i (comp_ge_i),
		.trial_o   (trial),
		.done_o    (sar_done)
	);

	always_comb begin
		s_d       = s_q;
		sar_clear = 1'b0;
		sar_step  = 1'b0;
		s_d.irq   = 1'b0;
		s_d.mux   = channel_select_field_i;
		// settle counter only informs software; it does not gate start
		if (!converter_enable_bit_i)
			s_d.settle = '0;
		else if (s_q.settle != 15'(SETTLE))
			s_d.settle = s_q.settle + 15'd1;
		s_d.settled = (s_d.settle == 15'(SETTLE));
		// the core is cleared at the end, so a deferred write uses the copy;
		// a fresh end-of-conversion write further down still wins
		if (s_q.pend && !result_rd_i) begin
			s_d.pend   = 1'b0;
			s_d.result = s_q.held;
		end
		case (s_q.st)
			acpf_pkg::ST_IDLE: begin
				if (conversion_start_bit_i && !standby_i) begin
					s_d.st    = acpf_pkg::ST_SAMPLE;
					s_d.cnt   = conv_cyc + 10'(`ACPF_FIRST_EXTRA);
					s_d.samp  = conv_cyc / 10'(`ACPF_SAMPLE_DIV);
					s_d.first = 1'b1;
					sar_clear = 1'b1;
				end
			end
			acpf_pkg::ST_SAMPLE: begin
				s_d.cnt  = s_q.cnt - 10'd1;
				s_d.samp = s_q.samp - 10'd1;
				if (s_q.samp == 10'd1) begin
					s_d.st   = acpf_pkg::ST_CONVERT;
					s_d.step = 6'((s_d.cnt) / 10'(RES));
				end
			end
			acpf_pkg::ST_CONVERT: begin
				s_d.cnt = s_q.cnt - 10'd1;
				if (!sar_done && s_q.step != 6'd0 &&
				    s_q.cnt % 10'(s_q.step) == 10'd0)
					sar_step = 1'b1;
				if (end_ev) begin
					if (!mode_wr_i && !channel_wr_i) begin
						if (result_rd_i) begin
							s_d.pend = 1'b1;
							s_d.held = trial;
						end else
							s_d.result = trial;
						if (!power_fail_enable_bit_i || hit)
							s_d.irq = 1'b1;
					end
					s_d.st    = acpf_pkg::ST_SAMPLE;
					s_d.cnt   = conv_cyc;
					s_d.samp  = conv_cyc / 10'(`ACPF_SAMPLE_DIV);
					s_d.first = 1'b0;
					sar_clear = 1'b1;
				end
			end
			default: s_d.st = acpf_pkg::ST_IDLE;
		endcase
		// a rewrite restarts the conversion in progress
		if (s_q.st != acpf_pkg::ST_IDLE && reg_wr) begin
			s_d.st   = acpf_pkg::ST_SAMPLE;
			s_d.cnt  = conv_cyc;
			s_d.samp = conv_cyc / 10'(`ACPF_SAMPLE_DIV);
			sar_clear = 1'b1;
		end
		if (!conversion_start_bit_i || standby_i) begin
			s_d.st  = acpf_pkg::ST_IDLE;
			s_d.irq = 1'b0;
		end
		// set beats clear; channel writes never touch the flag
		if (irq_flag_clr_i)
			s_d.flag = 1'b0;
		if (s_d.irq)
			s_d.flag = 1'b1;
		s_d.sample = (s_d.st == acpf_pkg::ST_SAMPLE);
		s_d.busy   = (s_d.st != acpf_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q        <= '0;
			s_q.st     <= acpf_pkg::ST_IDLE;
			s_q.result <= `ACPF_RESULT_RST;
		end else
			s_q <= s_d;
	end

	assign dac_code_o            = trial;
	assign mux_sel_o             = s_q.mux;
	assign sample_o              = s_q.sample;
	assign conversion_result_o   = s_q.result;
	assign conversion_end_irq_o  = s_q.irq;
	assign conversion_irq_flag_o = s_q.flag;
	assign busy_o                = s_q.busy;
	assign settled_o             = s_q.settled;

	chk_irq_sets_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conversion_end_irq_o |-> conversion_irq_flag_o)
		else $error("irq without flag");
	chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conversion_irq_flag_o && !irq_flag_clr_i |=> conversion_irq_flag_o)
		else $error("flag dropped without clear");
	chk_stop_now: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!conversion_start_bit_i |=> !busy_o)
		else $error("still busy after stop");
	chk_standby_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
		standby_i |=> !busy_o && !conversion_end_irq_o)
		else $error("running in standby");
	chk_wr_suppress: assert property (@(posedge clk_i) disable iff (!rstn_i)
		end_ev && channel_wr_i |=> !conversion_end_irq_o)
		else $error("irq despite channel write");
	chk_pf_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		end_ev && !reg_wr && conversion_start_bit_i && !standby_i
		&& power_fail_enable_bit_i && !hit |=> !conversion_end_irq_o)
		else $error("irq without compare hit");
	chk_repeat: assert property (@(posedge clk_i) disable iff (!rstn_i)
		end_ev && conversion_start_bit_i && !standby_i |=> sample_o)
		else $error("no next conversion");
	chk_rd_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
		end_ev && result_rd_i && !mode_wr_i && !channel_wr_i
		|=> $stable(conversion_result_o))
		else $error("result changed during read");
	chk_rd_lands: assert property (@(posedge clk_i) disable iff (!rstn_i)
		end_ev && result_rd_i && !mode_wr_i && !channel_wr_i ##1 !result_rd_i
		|=> conversion_result_o == $past(trial, 2))
		else $error("held result not written");
	chk_rewrite: assert property (@(posedge clk_i) disable iff (!rstn_i)
		busy_o && threshold_wr_i && conversion_start_bit_i && !standby_i
		|=> sample_o)
		else $error("rewrite did not restart");
endmodule : acpf_ctrl
`default_nettype wire

// ### acpf_analog_model.sv
// ideal analog front end: eight input levels and the comparator
`timescale 1ns/1ps
`default_nettype none
module acpf_analog_model (
	input  wire logic [79:0] vin_i,
	input  wire logic [2:0]  mux_sel_i,
	input  wire logic [9:0]  dac_code_i,
	output logic             comp_ge_o
);
	// the shared port pins are never touched while converting
	// noiseless, so a correct search lands exactly on the level
	assign comp_ge_o = vin_i[mux_sel_i*10 +: 10] >= dac_code_i;
endmodule : acpf_analog_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acpf_params.svh"
module testbench;
	typedef struct packed {
		logic [2:0] rate;
		logic [2:0] ch;
		logic       pf;
		logic       cond;
		logic       off;
		logic       irq;
	} acpf_row_s;
	localparam int ST = `ACPF_SETTLE_CYC;
	logic        clk_i = 0, rstn_i = 0, en = 0, st = 0, pf = 0, cond = 0;
	logic        cwr = 0, clr = 0, sb = 0, cge, smp, irq, flag, busy, settled;
	logic        rd = 0, mwr = 0, pmw = 0, twr = 0;
	logic [2:0]  rate = 0, ch = 0, mux;
	logic [7:0]  thr = 0;
	logic [9:0]  dac, res;
	logic [79:0] vin = {10'h37c, 10'h000, 10'h001, 10'h0ff,
		10'h200, 10'h155, 10'h2a5, 10'h3ff};
	int          miscompares = 0, n_tests = 0, n;
	// rate, channel, power-fail, condition, threshold offset, irq expected
	acpf_row_s   rows [7] = '{'{0, 0, 0, 0, 0, 1}, '{1, 1, 1, 0, 0, 1},
		'{2, 2, 1, 0, 1, 0}, '{4, 3, 1, 1, 0, 0}, '{5, 4, 1, 1, 1, 1},
		'{6, 5, 0, 0, 0, 1}, '{7, 6, 0, 0, 0, 1}};
	acpf_ctrl #(.SETTLE(ST)) acpf_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.converter_enable_bit_i(en), .conversion_start_bit_i(st),
		.conversion_rate_field_i(rate), .channel_select_field_i(ch),
		.power_fail_enable_bit_i(pf), .compare_condition_bit_i(cond),
		.threshold_i(thr), .mode_wr_i(mwr), .channel_wr_i(cwr),
		.cmpmode_wr_i(pmw), .threshold_wr_i(twr), .result_rd_i(rd),
		.irq_flag_clr_i(clr), .standby_i(sb), .comp_ge_i(cge),
		.dac_code_o(dac), .mux_sel_o(mux), .sample_o(smp),
		.conversion_result_o(res), .conversion_end_irq_o(irq),
		.conversion_irq_flag_o(flag), .busy_o(busy), .settled_o(settled));
	acpf_analog_model acpf_analog_model_inst (.vin_i(vin), .mux_sel_i(mux),
		.dac_code_i(dac), .comp_ge_o(cge));
	initial forever #50 clk_i = ~clk_i;
	function automatic int conv(input logic [2:0] r);
		case (r)
			3'h1: return 240;
			3'h2: return 192;
			3'h4: return 144;
			3'h5: return 120;
			3'h6: return 96;
			default: return 288;
		endcase
	endfunction : conv
	task automatic end_of_test();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic fail(input string m);
		miscompares++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail
	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) fail("flag mismatch");
	endtask : chk1
	task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) fail("result mismatch");
	endtask : chk10
	task automatic chk_n(input int got, input int exp);
		n_tests++;
		if (got != exp) fail("interrupt at wrong time");
	endtask : chk_n
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic wait_irq(input int max);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (irq !== 1'b1 && n < max);
		if (irq !== 1'b1) begin
			fail("no interrupt in time");
			end_of_test();
		end
	endtask : wait_irq
	task automatic quiet(input int k);
		repeat (k) begin
			tick(1);
			chk1(irq, 1'b0);
		end
	endtask : quiet
	task automatic stop_clear();
		@(posedge clk_i);
		st <= 1'b0;
		@(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		tick(2);
	endtask : stop_clear
	initial begin
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		tick(1);
		chk10(res, 10'h000);
		chk1(flag, 1'b0);
		chk1(settled, 1'b0);
		@(posedge clk_i);
		en <= 1'b1;
		tick(ST + 3);
		chk1(settled, 1'b1);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			rate <= rows[i].rate;
			ch <= rows[i].ch;
			pf <= rows[i].pf;
			cond <= rows[i].cond;
			thr <= 8'(vin[rows[i].ch*10+2 +: 8] + rows[i].off);
			@(posedge clk_i);
			st <= 1'b1;
			if (rows[i].irq) begin
				wait_irq(conv(rows[i].rate) + 50);
				chk_n(n, conv(rows[i].rate) + `ACPF_FIRST_EXTRA + 1);
			end else
				quiet(conv(rows[i].rate) + 50);
			chk10(res, vin[rows[i].ch*10 +: 10]);
			stop_clear();
		end
		@(posedge clk_i);
		rate <= 3'h6;
		ch <= 3'h7;
		pf <= 1'b0;
		@(posedge clk_i);
		st <= 1'b1;
		wait_irq(180);
		wait_irq(110);
		chk_n(n, conv(3'h6));
		tick(5);
		chk1(flag, 1'b1);
		@(posedge clk_i);
		ch <= 3'h0;
		cwr <= 1'b1;
		@(posedge clk_i);
		cwr <= 1'b0;
		#1;
		chk1(flag, 1'b1);
		chk10({7'h00, mux}, 10'h000);
		wait_irq(110);
		chk_n(n, conv(3'h6));
		chk10(res, 10'h3ff);
		chk1(smp, 1'b1);
		chk10(dac, 10'h200);
		@(posedge clk_i);
		vin[9:0] <= 10'h123;
		repeat (14) @(posedge clk_i);
		#1;
		chk1(smp, 1'b1);
		@(posedge clk_i);
		#1;
		chk1(smp, 1'b0);
		// the read lands on the very edge that ends the conversion
		repeat (79) @(posedge clk_i);
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk1(irq, 1'b1);
		chk10(res, 10'h3ff);
		tick(1);
		chk10(res, 10'h123);
		@(posedge clk_i);
		vin[9:0] <= 10'h0c3;
		repeat (93) @(posedge clk_i);
		cwr <= 1'b1;
		@(posedge clk_i);
		cwr <= 1'b0;
		#1;
		chk1(irq, 1'b0);
		chk10(res, 10'h123);
		wait_irq(110);
		chk_n(n, conv(3'h6));
		chk10(res, 10'h0c3);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			{mwr, pmw, twr} <= 3'h1 << k;
			@(posedge clk_i);
			{mwr, pmw, twr} <= 3'h0;
			#1;
			wait_irq(110);
			chk_n(n, conv(3'h6));
		end
		stop_clear();
		chk1(flag, 1'b0);
		@(posedge clk_i);
		st <= 1'b1;
		repeat (30) @(posedge clk_i);
		st <= 1'b0;
		tick(2);
		chk1(busy, 1'b0);
		quiet(150);
		@(posedge clk_i);
		sb <= 1'b1;
		st <= 1'b1;
		quiet(200);
		chk1(busy, 1'b0);
		@(posedge clk_i);
		sb <= 1'b0;
		wait_irq(180);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		tick(2);
		chk1(busy, 1'b0);
		chk1(flag, 1'b0);
		chk10(res, `ACPF_RESULT_RST);
		@(posedge clk_i);
		rstn_i <= 1'b1;
		wait_irq(180);
		chk_n(n, conv(3'h6) + `ACPF_FIRST_EXTRA + 1);
		stop_clear();
		@(posedge clk_i);
		en <= 1'b0;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
